// File: rtl/svwdr_top.sv
// Supervisor reset generator with watchdog timer and manual reset
`timescale 1ns/1ns
`default_nettype none
module svwdr_top #(
  parameter int unsigned TICK_CYC = svwdr_pkg::TICK_CYC,
  parameter int unsigned WD_TICKS = svwdr_pkg::WD_TICKS,
  parameter int unsigned HOLD_TICKS = svwdr_pkg::HOLD_TICKS,
  parameter int unsigned DRV_TICKS = svwdr_pkg::DRV_TICKS,
  parameter int unsigned MR_FILT_CYC = svwdr_pkg::MR_FILT_CYC,
  parameter bit OUT_ACTIVE_HIGH = 1'b0,
  parameter bit OPEN_DRAIN = 1'b0
) (
  // Clock and synchronous reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Supply comparator, high while supply is below trip threshold
  input wire logic SUPPLY_BELOW_TRIP_I,
  // Manual reset pin, active low
  input wire logic MANUAL_RESET_LOW_N_I,
  // Watchdog strobe pin, two-way through the internal series resistor
  input wire logic WATCHDOG_STROBE_IN_I,
  output logic WATCHDOG_STROBE_IN_O,
  output logic WATCHDOG_STROBE_IN_OE_N_O,
  // System reset pin
  output logic SYS_RESET_LOW_OUT_O,
  output logic SYS_RESET_LOW_OUT_OE_N_O
);

  // ----------------------------------------------------------------
  // Derived widths and terminal counts
  // ----------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int WW = $clog2(WD_TICKS + 1);
  localparam int HW = $clog2(HOLD_TICKS + 1);
  localparam int DW = $clog2(DRV_TICKS + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
  localparam logic [WW-1:0] WD_LAST = WW'(WD_TICKS - 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_TICKS - 1);
  localparam logic [DW-1:0] DRV_LAST = DW'(DRV_TICKS - 1);
  // First tick of the high part of the internal driver period
  localparam logic [DW-1:0] DRV_HI_START = DW'((DRV_TICKS *
    svwdr_pkg::DRV_LOW_EIGHTHS) / svwdr_pkg::DRV_EIGHTHS);

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  svwdr_cond_if cond_if ();

  svwdr_cond #(
    .FILT_CYC(MR_FILT_CYC)
  ) u_cond (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .supply_below_trip_i(SUPPLY_BELOW_TRIP_I),
    .manual_reset_low_n_i(MANUAL_RESET_LOW_N_I),
    .watchdog_strobe_in_i(WATCHDOG_STROBE_IN_I),
    .ev(cond_if.cond)
  );

  // ----------------------------------------------------------------
  // Timebase divider
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt_r;
  logic [TW-1:0] tick_cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // One-cycle enable every TICK_CYC clocks drives all slow timers
  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 1'b1;
    if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  // Divider registers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer and watchdog timer
  // ----------------------------------------------------------------
  svwdr_pkg::svwdr_state_t state_r;
  svwdr_pkg::svwdr_state_t state_nxt;
  logic [HW-1:0] hold_cnt_r;
  logic [HW-1:0] hold_cnt_nxt;
  logic [WW-1:0] wd_cnt_r;
  logic [WW-1:0] wd_cnt_nxt;
  logic cause;
  logic rst_act;

  // Level causes; watchdog expiry is handled inside the run state
  assign cause = cond_if.supply_fault | cond_if.manual_req;
  assign rst_act = (state_r != svwdr_pkg::ST_RUN);

  // A level cause always wins over a running stretch and restarts it,
  // so once a cause has come, the hold time is measured from its last release
  always_comb begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    wd_cnt_nxt = '0;
    case (state_r)
      svwdr_pkg::ST_RUN: begin
        hold_cnt_nxt = '0;
        if (cause) begin
          state_nxt = svwdr_pkg::ST_ASSERT;
        end else if (cond_if.strobe_edge) begin
          wd_cnt_nxt = '0;
        end else if (tick_r && (wd_cnt_r == WD_LAST)) begin
          state_nxt = svwdr_pkg::ST_STRETCH;
        end else if (tick_r) begin
          wd_cnt_nxt = wd_cnt_r + 1'b1;
        end else begin
          wd_cnt_nxt = wd_cnt_r;
        end
      end
      svwdr_pkg::ST_ASSERT: begin
        hold_cnt_nxt = '0;
        if (!cause) begin
          state_nxt = svwdr_pkg::ST_STRETCH;
        end
      end
      svwdr_pkg::ST_STRETCH: begin
        if (cause) begin
          state_nxt = svwdr_pkg::ST_ASSERT;
          hold_cnt_nxt = '0;
        end else if (tick_r && (hold_cnt_r == HOLD_LAST)) begin
          state_nxt = svwdr_pkg::ST_RUN;
          hold_cnt_nxt = '0;
        end else if (tick_r) begin
          hold_cnt_nxt = hold_cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = svwdr_pkg::ST_ASSERT;
        hold_cnt_nxt = '0;
      end
    endcase
  end

  // Power-up enters the stretch, so reset is held a full hold time
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r <= svwdr_pkg::ST_STRETCH;
      hold_cnt_r <= '0;
      wd_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      wd_cnt_r <= wd_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Internal strobe driver
  // ----------------------------------------------------------------
  logic [DW-1:0] drv_cnt_r;
  logic [DW-1:0] drv_cnt_nxt;
  logic drv_r;
  logic drv_nxt;

  // Runs free; its high part comes early enough that a floating pin
  // toggles the strobe before the watchdog period can run out.
  // The series resistor lets any external driver override it.
  always_comb begin
    drv_cnt_nxt = drv_cnt_r;
    if (tick_r) begin
      drv_cnt_nxt = (drv_cnt_r == DRV_LAST) ? '0 : drv_cnt_r + 1'b1;
    end
    drv_nxt = (drv_cnt_nxt >= DRV_HI_START);
  end

  // Driver registers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      drv_cnt_r <= '0;
      drv_r <= 1'b0;
    end else begin
      drv_cnt_r <= drv_cnt_nxt;
      drv_r <= drv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic act_nxt;
  logic rst_out_r;
  logic rst_out_nxt;
  logic rst_oe_n_r;
  logic rst_oe_n_nxt;
  logic strobe_oe_n_r;

  // Polarity and drive type are fixed per variant by parameter
  always_comb begin
    act_nxt = (state_nxt != svwdr_pkg::ST_RUN);
    if (OPEN_DRAIN) begin
      rst_out_nxt = 1'b0;
      rst_oe_n_nxt = ~act_nxt;
    end else begin
      rst_out_nxt = OUT_ACTIVE_HIGH ? act_nxt : ~act_nxt;
      rst_oe_n_nxt = 1'b0;
    end
  end

  // Reset state drives the asserted level from the first edge
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rst_out_r <= (OPEN_DRAIN || !OUT_ACTIVE_HIGH) ? 1'b0 : 1'b1;
      rst_oe_n_r <= 1'b0;
      strobe_oe_n_r <= 1'b0;
    end else begin
      rst_out_r <= rst_out_nxt;
      rst_oe_n_r <= rst_oe_n_nxt;
      strobe_oe_n_r <= 1'b0;
    end
  end

  assign SYS_RESET_LOW_OUT_O = rst_out_r;
  assign SYS_RESET_LOW_OUT_OE_N_O = rst_oe_n_r;
  assign WATCHDOG_STROBE_IN_O = drv_r;
  assign WATCHDOG_STROBE_IN_OE_N_O = strobe_oe_n_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  logic pin_asserted;
  assign pin_asserted = OPEN_DRAIN ? !rst_oe_n_r :
    (rst_out_r == OUT_ACTIVE_HIGH);

  sequence s_cause_cleared;
    (state_r == svwdr_pkg::ST_ASSERT) ##1
      (state_r == svwdr_pkg::ST_STRETCH);
  endsequence

  sequence s_released;
    rst_act ##1 !rst_act;
  endsequence

  property p_supply_asserts;
    cond_if.supply_fault |=> rst_act && pin_asserted;
  endproperty
  a_supply_asserts: assert property (p_supply_asserts)
    else $error("Supply fault did not assert reset");

  property p_stretch_from_zero;
    s_cause_cleared |-> (hold_cnt_r == '0);
  endproperty
  a_stretch_from_zero: assert property (p_stretch_from_zero)
    else $error("Hold stretch did not start from zero");

  property p_full_hold;
    s_released |-> ($past(hold_cnt_r) == HOLD_LAST) && $past(tick_r);
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("Reset released before full hold time");

  property p_wd_expiry;
    (state_r == svwdr_pkg::ST_RUN) && !cause && tick_r &&
      !cond_if.strobe_edge && (wd_cnt_r == WD_LAST)
      |=> (state_r == svwdr_pkg::ST_STRETCH) ##1 pin_asserted;
  endproperty
  a_wd_expiry: assert property (p_wd_expiry)
    else $error("Watchdog expiry did not start reset stretch");

  property p_wd_cleared;
    rst_act |-> (wd_cnt_r == '0);
  endproperty
  a_wd_cleared: assert property (p_wd_cleared)
    else $error("Watchdog counter moved while reset asserted");

  property p_wd_from_zero;
    s_released |-> (wd_cnt_r == '0);
  endproperty
  a_wd_from_zero: assert property (p_wd_from_zero)
    else $error("Watchdog did not start from zero at release");

  property p_strobe_clears;
    cond_if.strobe_edge |=> (wd_cnt_r == '0);
  endproperty
  a_strobe_clears: assert property (p_strobe_clears)
    else $error("Strobe toggle did not clear watchdog");

  property p_drv_rise;
    $rose(drv_r) |-> (drv_cnt_r == DRV_HI_START);
  endproperty
  a_drv_rise: assert property (p_drv_rise)
    else $error("Internal driver rose at wrong point");

  property p_manual_holds;
    cond_if.manual_req |=> rst_act [*2];
  endproperty
  a_manual_holds: assert property (p_manual_holds)
    else $error("Manual reset did not hold reset");

  property p_pin_follows;
    rst_act |-> pin_asserted;
  endproperty
  a_pin_follows: assert property (p_pin_follows)
    else $error("Reset pin not at asserted level");

endmodule
`default_nettype wire

// File: rtl/svwdr_pkg.sv
// Constants, timing figures and state encoding of the supervisor block
`default_nettype none
package svwdr_pkg;

  // ----------------------------------------------------------------
  // System clock and internal timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS = 1000;
  // Timebase divider length, rounded up so a tick is never short
  localparam int unsigned TICK_CYC =
    (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned TICKS_PER_MS = NS_PER_MS / TICK_NS;

  // ----------------------------------------------------------------
  // Supervisor timing figures
  // ----------------------------------------------------------------
  localparam int unsigned WD_PERIOD_MS = 1500;
  localparam int unsigned HOLD_MS = 140;
  localparam int unsigned DRV_PERIOD_MS = 1400;
  localparam int unsigned WD_TICKS = WD_PERIOD_MS * TICKS_PER_MS;
  localparam int unsigned HOLD_TICKS = HOLD_MS * TICKS_PER_MS;
  localparam int unsigned DRV_TICKS = DRV_PERIOD_MS * TICKS_PER_MS;
  // Internal driver is low for seven of eight parts of its period
  localparam int unsigned DRV_LOW_EIGHTHS = 7;
  localparam int unsigned DRV_EIGHTHS = 8;

  // ----------------------------------------------------------------
  // Input pin timing
  // ----------------------------------------------------------------
  localparam int unsigned STROBE_MIN_NS = 50;
  localparam int unsigned MR_MIN_NS = 1000;
  localparam int unsigned MR_REJECT_NS = 90;
  // Manual input must stand this long; half the least accepted pulse
  localparam int unsigned MR_FILT_CYC = (MR_MIN_NS / 2) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_ASSERT = 2'h1,
    ST_STRETCH = 2'h2
  } svwdr_state_t;

endpackage
`default_nettype wire

// File: rtl/svwdr_cond_if.sv
// Conditioned input events passed from the pin conditioner to the core
`timescale 1ns/1ns
`default_nettype none
interface svwdr_cond_if;
  logic supply_fault;
  logic manual_req;
  logic strobe_edge;
  modport cond (output supply_fault, output manual_req, output strobe_edge);
  modport core (input supply_fault, input manual_req, input strobe_edge);
endinterface
`default_nettype wire

// File: rtl/svwdr_cond.sv
// Pin synchronisers, manual reset glitch filter and strobe edge detect
`timescale 1ns/1ns
`default_nettype none
module svwdr_cond #(
  parameter int unsigned FILT_CYC = svwdr_pkg::MR_FILT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw pins
  input wire logic supply_below_trip_i,
  input wire logic manual_reset_low_n_i,
  input wire logic watchdog_strobe_in_i,
  // Conditioned events
  svwdr_cond_if.cond ev
);

  localparam int FW = $clog2(FILT_CYC + 1);
  localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYC - 1);

  // ----------------------------------------------------------------
  // Synchronisers: bit 0 supply, bit 1 manual, bit 2 strobe
  // ----------------------------------------------------------------
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic strobe_d_r;
  logic mr_low_r;
  logic [FW-1:0] mr_cnt_r;
  logic mr_low_nxt;
  logic [FW-1:0] mr_cnt_nxt;

  // Manual filter: a level must stand FILT_CYC cycles to be taken,
  // so a sub-cycle glitch can never flip the filtered level
  always_comb begin
    mr_low_nxt = mr_low_r;
    mr_cnt_nxt = '0;
    if (~sync_r[1] != mr_low_r) begin
      if (mr_cnt_r == FILT_LAST) begin
        mr_low_nxt = ~sync_r[1];
      end else begin
        mr_cnt_nxt = mr_cnt_r + 1'b1;
      end
    end
  end

  // Register stage; the first flop feeds only the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= 3'h2;
      sync_r <= 3'h2;
      strobe_d_r <= 1'b0;
      mr_low_r <= 1'b0;
      mr_cnt_r <= '0;
    end else begin
      meta_r <= {watchdog_strobe_in_i, manual_reset_low_n_i,
                 supply_below_trip_i};
      sync_r <= meta_r;
      strobe_d_r <= sync_r[2];
      mr_low_r <= mr_low_nxt;
      mr_cnt_r <= mr_cnt_nxt;
    end
  end

  // Event outputs; any strobe transition counts as a toggle
  assign ev.supply_fault = sync_r[0];
  assign ev.manual_req = mr_low_r;
  assign ev.strobe_edge = sync_r[2] ^ strobe_d_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mr_filter;
    @(posedge clk_i) disable iff (!rst_n_i)
    $changed(mr_low_r) |-> $past(mr_cnt_r) == FILT_LAST;
  endproperty
  a_mr_filter: assert property (p_mr_filter)
    else $error("Manual level changed before filter time");

endmodule
`default_nettype wire

// File: verification/svwdr_host_model.sv
// Behavioural host processor that services the watchdog strobe pin
`timescale 1ns/1ns
`default_nettype none
module svwdr_host_model #(
  parameter int unsigned PERIOD_CYC = 50,
  parameter int unsigned PULSE_CYC = 2
) (
  // Clock
  input wire logic clk_i,
  // Behaviour select: 0 serve, 1 stall, 2 float
  input wire logic [1:0] mode_i,
  // Strobe pin drive
  output logic strobe_en_o,
  output logic strobe_val_o
);
  int unsigned cnt_r;

  // ----------------------------------------------------------------
  // Strobe pattern
  // ----------------------------------------------------------------
  // Low most of the time with one short high pulse early in each
  // period, which keeps pin current low on the real part
  always_ff @(posedge clk_i) begin
    cnt_r <= (cnt_r >= PERIOD_CYC - 1) ? 0 : cnt_r + 1;
    case (mode_i)
      2'h0: begin
        strobe_en_o <= 1'b1;
        strobe_val_o <= (cnt_r < PULSE_CYC);
      end
      2'h1: begin
        // Hung software: pin held, no toggles at all
        strobe_en_o <= 1'b1;
        strobe_val_o <= 1'b0;
      end
      default: begin
        // Buffer in high impedance; stale value is scrambled
        strobe_en_o <= 1'b0;
        strobe_val_o <= ~strobe_val_o;
      end
    endcase
  end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the supervisor reset generator
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Shortened timing so whole periods fit in a brief run
  // ----------------------------------------------------------------
  localparam int unsigned TICK = 2;
  localparam int unsigned WDT = 40;
  localparam int unsigned HLD = 10;
  localparam int unsigned DRV = 32;
  localparam int unsigned FILT = 5;
  localparam int HOLD_CYC = HLD * TICK;
  localparam int WD_CYC = WDT * TICK;
  localparam int DRV_CYC = DRV * TICK;
  localparam int DRV_HI = (DRV / 8) * TICK;
  localparam int LIMIT = 20000;

  typedef struct {
    int lo;
    int hi;
  } svwdr_note_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply = 1'b0;
  logic mr_n = 1'b1;
  logic [1:0] mode = 2'h0;
  logic strobe_int;
  logic strobe_oe_n;
  logic sys_rst;
  logic rst_oe_n;
  logic host_en;
  logic host_val;
  wire strobe_pin;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int width = 0;
  logic was_on = 1'b0;
  logic [31:0] seed = 32'h0001_4179;
  svwdr_note_t notes[$];
  svwdr_note_t cur;

  // ----------------------------------------------------------------
  // Clock, pin resolution and instances
  // ----------------------------------------------------------------
  always #50 clk = ~clk;

  // Host drive wins over the weak internal driver behind its resistor
  assign strobe_pin = (host_en === 1'b1) ? host_val :
                      ((strobe_oe_n === 1'b0) ? strobe_int : 1'b0);

  svwdr_top #(
    .TICK_CYC(TICK),
    .WD_TICKS(WDT),
    .HOLD_TICKS(HLD),
    .DRV_TICKS(DRV),
    .MR_FILT_CYC(FILT)
  ) svwdr_top_inst (
    .CLK_I(clk),
    .RST_N_I(rst_n),
    .SUPPLY_BELOW_TRIP_I(supply),
    .MANUAL_RESET_LOW_N_I(mr_n),
    .WATCHDOG_STROBE_IN_I(strobe_pin),
    .WATCHDOG_STROBE_IN_O(strobe_int),
    .WATCHDOG_STROBE_IN_OE_N_O(strobe_oe_n),
    .SYS_RESET_LOW_OUT_O(sys_rst),
    .SYS_RESET_LOW_OUT_OE_N_O(rst_oe_n)
  );

  svwdr_host_model #(
    .PERIOD_CYC(50),
    .PULSE_CYC(2)
  ) svwdr_host_model_inst (
    .clk_i(clk),
    .mode_i(mode),
    .strobe_en_o(host_en),
    .strobe_val_o(host_val)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic compare_range(input string what, input int lo,
                               input int hi, input int seen);
    num_checks++;
    if (seen < lo || seen > hi) begin
      err_total++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask

  task automatic push_note(input int lo, input int hi);
    svwdr_note_t nt;
    nt.lo = lo;
    nt.hi = hi;
    notes.push_back(nt);
  endtask

  // Holds one cause for d cycles; inputs change only by NBA at an edge
  task automatic cause(input logic manual, input int d);
    if (manual) begin
      mr_n <= 1'b0;
    end else begin
      supply <= 1'b1;
    end
    repeat (d) @(posedge clk);
    mr_n <= 1'b1;
    supply <= 1'b0;
  endtask

  // Bounded wait for the reset pin to reach a level
  task automatic wait_level(input logic lvl, input int max, output int n);
    n = 0;
    while (sys_rst !== lvl && n < max) begin
      @(posedge clk);
      n++;
    end
    compare_range("wait for reset pin", 0, max - 1, n);
  endtask

  task automatic finish_test();
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitor: each reset pulse width against the oldest note
  // ----------------------------------------------------------------
  // An unknown pin level counts as asserted so it can never pass
  always @(posedge clk) begin
    if (!rst_n) begin
      width = 0;
      was_on = 1'b1;
    end else if (sys_rst !== 1'b1) begin
      width++;
      was_on = 1'b1;
    end else if (was_on) begin
      was_on = 1'b0;
      if (notes.size() == 0) begin
        compare_range("unexpected reset", 0, -1, width);
      end else begin
        cur = notes.pop_front();
        compare_range("reset width", cur.lo, cur.hi, width);
      end
      // Push-pull variant keeps its reset pin enable on at all times
      compare_range("pin enable", 0, 0, int'(rst_oe_n !== 1'b0));
      width = 0;
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      $display("Error run length expected below %0d seen %0d", LIMIT,
               cycles);
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int d;
    int n;
    int glitch[2];
    glitch = '{1, 3};
    repeat (5) @(posedge clk);
    push_note(HOLD_CYC - 4, HOLD_CYC + 6);
    rst_n <= 1'b1;
    @(posedge clk);
    wait_level(1'b1, 100, n);
    // Supply and manual causes alternate, random lengths
    for (int i = 0; i < 6; i++) begin
      seed = xorshift(seed);
      d = 10 + int'(seed % 32'h0000_001F);
      push_note(d + HOLD_CYC - 6, d + HOLD_CYC + 8);
      cause(i[0], d);
      wait_level(1'b1, 200, n);
      repeat (20) @(posedge clk);
    end
    // Short manual glitches must not reach the output
    foreach (glitch[k]) begin
      cause(1'b1, glitch[k]);
      repeat (40) @(posedge clk);
    end
    // Serviced watchdog with short pulses stays quiet
    repeat (300) @(posedge clk);
    // Release the pin just after a host pulse, then watch the driver
    while (host_val !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    mode <= 2'h2;
    repeat (DRV_CYC + 8) @(posedge clk);
    n = 0;
    for (int k = 0; k < DRV_CYC; k++) begin
      @(posedge clk);
      if (strobe_int === 1'b1) n++;
    end
    compare_range("driver high cycles", DRV_HI, DRV_HI, n);
    repeat (3 * DRV_CYC) @(posedge clk);
    // Long manual reset while the host hangs, then two expiries
    push_note(200 + HOLD_CYC - 6, 200 + HOLD_CYC + 8);
    push_note(HOLD_CYC - 4, HOLD_CYC + 6);
    push_note(HOLD_CYC - 4, HOLD_CYC + 6);
    mode <= 2'h1;
    cause(1'b1, 200);
    wait_level(1'b1, 200, n);
    for (int k = 0; k < 2; k++) begin
      wait_level(1'b0, 200, n);
      compare_range("expiry gap", WD_CYC - 4, WD_CYC + 6, n);
      wait_level(1'b1, 200, n);
    end
    mode <= 2'h0;
    repeat (300) @(posedge clk);
    compare_range("notes left", 0, 0, notes.size());
    finish_test();
  end
endmodule
`default_nettype wire
